/* verilog/imp_pkg.sv */
// Purpose: Shared constants for the interrupt mask, poll and end-of-service block.
// Assumes: 16-bit register data on a plain strobe port, byte-style printed offsets.
// Notes:   Source bit positions are the same in the mask and in-service vectors.
package imp_pkg;
    // Register offsets.
    localparam logic [7:0] A_VEC   = 8'h20;
    localparam logic [7:0] A_EOI   = 8'h22;
    localparam logic [7:0] A_POLL  = 8'h24;
    localparam logic [7:0] A_PEEK  = 8'h26;
    localparam logic [7:0] A_MASK  = 8'h28;
    localparam logic [7:0] A_THR   = 8'h2A;
    localparam logic [7:0] A_CFG   = 8'h40;
    localparam logic [7:0] A_EVST  = 8'h42;
    localparam logic [7:0] A_EVCLR = 8'h44;
    localparam logic [7:0] A_EVEN  = 8'h46;
    // Source vector geometry and reset values.
    localparam int         NSRC     = 11;
    localparam int         PW       = 3;
    localparam logic [10:0] VALID_M = 11'h7FD;
    localparam logic [10:0] VALID_S = 11'h03D;
    localparam logic [10:0] MASK_RST = 11'h7FD;
    localparam logic [2:0] THR_RST  = 3'h7;
    localparam logic [4:0] VBASE_RST = 5'h00;
    // Source bit positions.
    localparam int B_TMR  = 0;
    localparam int B_DMA0 = 2;
    localparam int B_EXT0 = 4;
    localparam int B_EXT1 = 5;
    localparam int B_WD   = 9;
    localparam int B_SER  = 10;
    localparam int B_T1   = 4;
    localparam int B_T2   = 5;
    // Field positions.
    localparam int NONSPECIFIC_CLEAR_FLAG_BIT = 15;
    localparam int PEND_BIT  = 15;
    localparam int VEC_LSB   = 3;
    localparam int VEC_SHIFT = 2;
    localparam int CFG_SLAVE = 0;
    localparam int CFG_SFNM  = 1;
    // Event status bits.
    localparam int EV_NEW  = 0;
    localparam int EV_ACK  = 1;
    localparam int EV_ORPH = 2;
    localparam int NEV     = 3;
endpackage

/* verilog/imp_ctrl.sv */
// Purpose: Priority threshold, source mask, poll and end-of-service logic.
// Assumes: Peripheral requests are levels on clk; external pins are asynchronous.
// Notes:   Each source's programmed priority arrives from its control register.
//          The mask is one eleven-bit store; slave mode shows a subset.
//          A mode change keeps the mask, so software rewrites it.
//          A poll takes a source into service but calls no handler.
//          Priorities tie to the lower source index.
//          Types in master mode come from a table parameter.
//
// Overview of operation
// - Three-bit threshold, upper bits zero, resets seven.
// - Block requests with priority above threshold.
// - Zero is highest priority, seven lowest.
// - Mask bit one masks, mirrored to control.
// - Master mask layout, resets 07FD.
// - Slave mask layout, resets 003D.
// - Peek register mirrors poll, no side effect.
// - Poll read acknowledges reported pending interrupt.
// - Bit 15 pending; low five carry type.
// - Poll acknowledge sets in-service, no handler.
// - Master end-of-service: non-specific or typed.
// - Slave end-of-service clears selected level.
// - Slave vector base upper five type bits.
// - Vector offset is type times four.
// - In-service source raises no new request, except external inputs 0 and 1 under special nesting.
// - Master timer request ORs three timers.
`timescale 1ns/100ps
module imp_ctrl #(
    parameter logic [54:0] TYPE_MAP = 55'h0  // Arbitrary master type per source, five bits each.
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic [7:0]           addr,
    input  wire logic [15:0]          wdata,
    input  wire logic                 wr_stb,
    input  wire logic                 rd_stb,
    output logic [15:0]               rdata,
    input  wire logic [2:0]           timer_req,
    input  wire logic [1:0]           dma_req,
    input  wire logic                 wdog_req,
    input  wire logic                 serial_req,
    input  wire logic [4:0]           ext_req_pin,
    input  wire logic [imp_pkg::NSRC*imp_pkg::PW-1:0] src_prio,
    output logic [imp_pkg::NSRC-1:0]  ctrl_mask,
    output logic [imp_pkg::NSRC-1:0]  ack_pulse,
    output logic                      cpu_int_req,
    output logic [7:0]                cpu_vec_type,
    output logic [9:0]                vec_offset,
    output logic                      evt_irq
);
    import imp_pkg::*;

    // Stored state.
    // Reserved bits are never stored, so they cannot read back.
    logic [NSRC-1:0] mask_reg;     // Source masks, master layout.
    logic [2:0]      thr_reg;      // Priority threshold.
    logic [4:0]      vbase_reg;    // Slave vector base.
    logic [1:0]      cfg_reg;      // Slave mode and special nesting.
    logic [NSRC-1:0] insvc_reg;    // In-service flags.
    logic [NEV-1:0]  ev_st_reg;    // Sticky event status.
    logic [NEV-1:0]  ev_en_reg;    // Event enables.
    logic [15:0]     rdata_reg;    // Read data, one cycle late.
    logic [NSRC-1:0] ack_reg;      // Acknowledge pulse to sources.
    logic            pend_d_reg;   // Pending seen last cycle.
    logic            int_reg;      // Interrupt request to the core.
    logic [7:0]      vec_reg;      // Type of the reported request.
    logic [4:0]      ext_s1_reg;   // First synchroniser stage.
    logic [4:0]      ext_s2_reg;   // Second synchroniser stage.

    // Next values.
    // Each next value is a continuous assignment of its own.
    logic [NSRC-1:0] mask_next;
    logic [2:0]      thr_next;
    logic [4:0]      vbase_next;
    logic [1:0]      cfg_next;
    logic [NSRC-1:0] insvc_next;
    logic [NEV-1:0]  ev_st_next;
    logic [NEV-1:0]  ev_en_next;
    logic [15:0]     rdata_next;

    // Priority of source i.
    // Every lookup goes through here, so the field layout lives in one place.
    function automatic logic [2:0] prio_at(input logic [NSRC*PW-1:0] p, input int i);
        return p[i*PW +: PW];
    endfunction

    // Best candidate: lowest priority value, lower index on a tie.
    // Scanning downward lets a tie settle on the lower index.
    function automatic logic [4:0] pick(input logic [NSRC-1:0] e, input logic [NSRC*PW-1:0] p);
        logic       f;
        logic [3:0] b;
        f = 1'b0;
        b = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (e[i] && (!f || prio_at(p, i) <= prio_at(p, int'(b)))) begin
                f = 1'b1;
                b = 4'(i);
            end
        end
        return {f, b};
    endfunction

    // One-hot vector for an index.
    function automatic logic [NSRC-1:0] onehot(input logic [3:0] i);
        return NSRC'(1) << i;
    endfunction

    // First source in set s whose priority equals l.
    // Used by slave end-of-service, where a level names the flag.
    function automatic logic [NSRC-1:0] first_lvl(input logic [NSRC-1:0] s,
                                                  input logic [NSRC*PW-1:0] p, input logic [2:0] l);
        logic [NSRC-1:0] r;
        r = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (s[i] && prio_at(p, i) == l) begin
                r = onehot(4'(i));
            end
        end
        return r;
    endfunction

    // Sources whose master type equals t.
    // Several sources may share a type; all of them are cleared.
    function automatic logic [NSRC-1:0] type_hits(input logic [4:0] t);
        logic [NSRC-1:0] r;
        r = '0;
        for (int i = 0; i < NSRC; i++) begin
            r[i] = (TYPE_MAP[i*5 +: 5] == t);
        end
        return r;
    endfunction

    // Mode decode.
    // Special nesting is a master-only feature; slave mode ignores it.
    wire logic            slave  = cfg_reg[CFG_SLAVE];
    wire logic            sfnm   = cfg_reg[CFG_SFNM] && !slave;
    wire logic [NSRC-1:0] valid  = slave ? VALID_S : VALID_M;

    // Bus decode; reads and writes never collide by bus contract.
    // Only the poll read has a side effect, so only it is decoded here.
    wire logic wr_vec  = wr_stb && addr == A_VEC;
    wire logic wr_eoi  = wr_stb && addr == A_EOI;
    wire logic wr_mask = wr_stb && addr == A_MASK;
    wire logic wr_thr  = wr_stb && addr == A_THR;
    wire logic wr_cfg  = wr_stb && addr == A_CFG;
    wire logic wr_evc  = wr_stb && addr == A_EVCLR;
    wire logic wr_eve  = wr_stb && addr == A_EVEN;
    wire logic rd_poll = rd_stb && addr == A_POLL;

    // Request vector; the master timer bit summarises three timers.
    // Only pins are synchronised; peripheral requests are already on clk.
    // Bit 1 stays zero, as no source sits there in either layout.
    wire logic [NSRC-1:0] req_m = {serial_req, wdog_req, ext_s2_reg, dma_req, 1'b0, |timer_req};
    wire logic [NSRC-1:0] req_s = {5'h00, timer_req[2], timer_req[1], dma_req, 1'b0, timer_req[0]};
    wire logic [NSRC-1:0] req_vec = slave ? req_s : req_m;

    // Per-source gating by mask, in-service and threshold.
    // All gates act before the pick, so a blocked source hides no other.
    logic [NSRC-1:0] thr_ok;
    logic [NSRC-1:0] ins_ok;
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            // Numerically larger priority values fall below the threshold.
            thr_ok[i] = prio_at(src_prio, i) <= thr_reg;
            // Two lowest external inputs may nest under special nesting.
            ins_ok[i] = !insvc_reg[i] || (sfnm && (i == B_EXT0 || i == B_EXT1));
        end
    end
    wire logic [NSRC-1:0] elig = req_vec & ~mask_reg & valid & ins_ok & thr_ok;

    // Highest-priority pending candidate.
    // A linear scan is cheap enough for eleven sources.
    wire logic [4:0] best    = pick(elig, src_prio);
    wire logic       any     = best[4];
    wire logic [3:0] best_ix = best[3:0];

    // Full eight-bit type of the candidate.
    // Master types come from a per-source table parameter.
    wire logic [7:0] type_s = {vbase_reg, prio_at(src_prio, int'(best_ix))};
    wire logic [7:0] type_m = {3'h0, TYPE_MAP[int'(best_ix)*5 +: 5]};
    wire logic [7:0] type8  = any ? (slave ? type_s : type_m) : 8'h00;

    // Poll word: pending flag and, only while pending, the type.
    wire logic [15:0] poll_word = {any, 10'h000, type8[4:0]};

    // A poll read takes the candidate into service; the core still has to call the handler.
    // With nothing pending, a poll read is a plain read.
    wire logic            poll_ack = rd_poll && any;
    wire logic [NSRC-1:0] ack_vec  = poll_ack ? onehot(best_ix) : '0;

    // End-of-service selection.
    // Non-specific clears the best in-service source; specific goes by type.
    // A write that clears nothing is reported as an event.
    wire logic [4:0]      ins_best = pick(insvc_reg, src_prio);
    wire logic [NSRC-1:0] ns_sel   = ins_best[4] ? onehot(ins_best[3:0]) : '0;
    wire logic [NSRC-1:0] sp_sel   = type_hits(wdata[4:0]) & insvc_reg;
    wire logic [NSRC-1:0] sl_sel   = first_lvl(insvc_reg & VALID_S, src_prio, wdata[2:0]);
    wire logic [NSRC-1:0] m_sel    = wdata[NONSPECIFIC_CLEAR_FLAG_BIT] ? ns_sel : sp_sel;
    wire logic [NSRC-1:0] eoi_sel  = wr_eoi ? (slave ? sl_sel : m_sel) : '0;
    wire logic            orphan   = wr_eoi && eoi_sel == '0;

    // Events: new pending, poll acknowledge, end-of-service with nothing to clear.
    // Each set term lasts one cycle at most.
    wire logic [NEV-1:0] ev_set = {orphan, poll_ack, any && !pend_d_reg};
    wire logic [NEV-1:0] ev_clr = wr_evc ? wdata[NEV-1:0] : '0;

    // Register next values; reserved bits are dropped on write.
    assign mask_next  = wr_mask ? (wdata[NSRC-1:0] & valid) | (mask_reg & ~valid) : mask_reg;
    assign thr_next   = wr_thr ? wdata[2:0] : thr_reg;
    assign vbase_next = wr_vec ? wdata[7:VEC_LSB] : vbase_reg;
    assign cfg_next   = wr_cfg ? wdata[1:0] : cfg_reg;
    // Acknowledge and end-of-service never share a cycle, so set and clear cannot meet.
    assign insvc_next = (insvc_reg & ~eoi_sel) | ack_vec;
    // A new event outranks a clear in the same cycle.
    assign ev_st_next = (ev_st_reg & ~ev_clr) | ev_set;
    assign ev_en_next = wr_eve ? wdata[NEV-1:0] : ev_en_reg;

    // Read multiplexer; write-only and unmapped offsets read zero.
    // Peek and poll share one word; only the strobe decode differs.
    // Unmapped offsets read zero rather than alias a register.
    wire logic [15:0] rd_mask = {5'h00, mask_reg & valid};
    wire logic [15:0] rd_thr  = {13'h0000, thr_reg};
    wire logic [15:0] rd_vec  = {8'h00, vbase_reg, 3'h0};
    wire logic [15:0] rd_sel  =
        (addr == A_POLL)  ? poll_word :
        (addr == A_PEEK)  ? poll_word :
        (addr == A_MASK)  ? rd_mask :
        (addr == A_THR)   ? rd_thr :
        (addr == A_VEC)   ? rd_vec :
        (addr == A_CFG)   ? {14'h0000, cfg_reg} :
        (addr == A_EVST)  ? {13'h0000, ev_st_reg} :
        (addr == A_EVEN)  ? {13'h0000, ev_en_reg} : 16'h0000;
    assign rdata_next = rd_stb ? rd_sel : 16'h0000;

    // External pins pass two flops before any logic sees them.
    // Both stages reset low, so an idle pin raises nothing after reset.
    // Only the second stage is read, which keeps metastability out.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_s1_reg <= 5'h00;
            ext_s2_reg <= 5'h00;
        end else begin
            ext_s1_reg <= ext_req_pin;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    // Software-visible configuration.
    // Reset gives master mode with every source masked.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg  <= MASK_RST;
            thr_reg   <= THR_RST;
            vbase_reg <= VBASE_RST;
            cfg_reg   <= 2'h0;
        end else begin
            mask_reg  <= mask_next;
            thr_reg   <= thr_next;
            vbase_reg <= vbase_next;
            cfg_reg   <= cfg_next;
        end
    end

    // Service state and event flags.
    // Hardware sets the in-service and status bits; software clears them through writes and writes the enables.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            insvc_reg <= '0;
            ev_st_reg <= '0;
            ev_en_reg <= '0;
        end else begin
            insvc_reg <= insvc_next;
            ev_st_reg <= ev_st_next;
            ev_en_reg <= ev_en_next;
        end
    end

    // Outputs toward the bus, the sources and the core.
    // Registered outputs keep bus decode glitches away from the core.
    // The request to the core lags eligibility by one cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg  <= 16'h0000;
            ack_reg    <= '0;
            pend_d_reg <= 1'b0;
            int_reg    <= 1'b0;
            vec_reg    <= 8'h00;
        end else begin
            rdata_reg  <= rdata_next;
            ack_reg    <= ack_vec;
            pend_d_reg <= any;
            int_reg    <= any;
            vec_reg    <= type8;
        end
    end

    // Output drive.
    // The mask output shows only the bits of the current layout.
    assign rdata        = rdata_reg;
    assign ctrl_mask    = mask_reg & valid;
    assign ack_pulse    = ack_reg;
    assign cpu_int_req  = int_reg;
    assign cpu_vec_type = vec_reg;
    // The offset is the type times four, to index the core's vector table.
    assign vec_offset   = {vec_reg, 2'b00};
    assign evt_irq      = |(ev_st_reg & ev_en_reg);

    // Checks.
    // The checks are off during reset, so that the sampled-value
    // functions never see flops on their way out of reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Is any eligible source strictly better than the reported one?
    // Helper for a_best_prio: set when the pick missed a better source.
    logic better;
    always_comb begin
        better = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (elig[i] && prio_at(src_prio, i) < prio_at(src_prio, int'(best_ix))) begin
                better = 1'b1;
            end
        end
    end

    a_thr_upper: assert property (rd_stb && addr == A_THR |=> rdata[15:3] == 13'h0000)
        else $error("threshold upper bits not zero");
    a_thr_block: assert property (any |-> prio_at(src_prio, int'(best_ix)) <= thr_reg)
        else $error("request above threshold reported");
    a_best_prio: assert property (any |-> !better)
        else $error("better pending source ignored");
    a_mask_mirror: assert property (wr_mask |=> ctrl_mask == ($past(wdata[10:0]) & valid))
        else $error("control mask not updated from write");
    a_mask_resv: assert property (rd_stb && addr == A_MASK && slave |=> rdata[15:6] == 10'h000)
        else $error("slave mask reserved bits set");
    a_peek_quiet: assert property (rd_stb && addr == A_PEEK |=> insvc_reg == $past(insvc_reg) && ack_pulse == '0)
        else $error("peek read changed service state");
    a_poll_ack: assert property (poll_ack |=> $onehot(ack_pulse) ##1 (ack_pulse == '0 || $past(poll_ack)))
        else $error("poll read did not acknowledge once");
    a_poll_word: assert property (rd_stb && (addr == A_POLL || addr == A_PEEK) |=>
        rdata[15] == $past(any) && (rdata[15] || rdata[4:0] == 5'h00))
        else $error("poll word flag or type wrong");
    a_ns_clear: assert property (wr_eoi && !slave && wdata[15] && insvc_reg != '0 |=>
        $countones(insvc_reg) + 1 == $countones($past(insvc_reg)))
        else $error("non-specific end-of-service did not clear one flag");
    a_no_reenter: assert property (any && insvc_reg[best_ix] |-> sfnm && (best_ix == 4'h4 || best_ix == 4'h5))
        else $error("in-service source raised again");
    a_timer_or: assert property (!slave && elig[B_TMR] |-> |timer_req)
        else $error("timer summary without a timer request");
    a_vec_shift: assert property (any |=> vec_offset[9:2] == $past(type8) && vec_offset[1:0] == 2'b00)
        else $error("vector offset not type times four");
    // Poll side effects: quiet outside polls, event set after one.
    a_ack_quiet: assert property (!poll_ack |=> ack_pulse == '0)
        else $error("acknowledge without a poll read");
    a_ack_event: assert property (poll_ack |=> ev_st_reg[EV_ACK])
        else $error("poll acknowledge event not recorded");
    // Register writes, read data and the core request.
    a_thr_write: assert property (wr_thr |=> thr_reg == $past(wdata[2:0]))
        else $error("threshold write lost");
    a_int_follow: assert property (any |=> cpu_int_req)
        else $error("core request missing");
    a_rdata_idle: assert property (!rd_stb |=> rdata == 16'h0000)
        else $error("read data outside a read cycle");
    // End-of-service by type in master mode and by level in slave mode.
    a_eoi_spec: assert property (wr_eoi && !slave && !wdata[NONSPECIFIC_CLEAR_FLAG_BIT] |=> (insvc_reg & $past(sp_sel)) == '0)
        else $error("specific end-of-service left a flag set");
    a_eoi_slave: assert property (wr_eoi && slave && sl_sel != '0 |=>
        $countones(insvc_reg) + 1 == $countones($past(insvc_reg)))
        else $error("slave end-of-service did not clear one flag");

    c_poll_ack: cover property (poll_ack ##1 ack_pulse != '0);
    c_eoi_ns: cover property (wr_eoi && wdata[15] && insvc_reg != '0);
    c_slave_eoi: cover property (slave && wr_eoi && sl_sel != '0);
    c_evt_irq: cover property (evt_irq);
    c_sfnm_nest: cover property (sfnm && any && insvc_reg[best_ix]);
endmodule

/* sim/imp_src_model.sv */
// Purpose: Peripheral request sources on the far side of the interrupt block.
// Assumes: Each source latches its request until the block acknowledges it.
// Notes:   Raw layout is [2:0] timers, [4:3] dma, [5] watchdog, [6] serial, [11:7] pins.
`timescale 1ns/100ps
module imp_src_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [11:0] set_raw,
    input  wire logic        slave,
    input  wire logic [10:0] ack_pulse,
    output logic [2:0]       timer_req,
    output logic [1:0]       dma_req,
    output logic             wdog_req,
    output logic             serial_req,
    output logic [4:0]       ext_req_pin
);
    logic [11:0] raw_reg;   // Latched request of every raw source.
    logic [11:0] raw_next;  // Next latched state.
    logic [11:0] clr;       // Sources retired by an acknowledge.
    // A master-mode timer acknowledge retires all three timers, since they share one source.
    assign clr = slave ? {7'h0, ack_pulse[3], ack_pulse[2], ack_pulse[5], ack_pulse[4], ack_pulse[0]}
                       : {ack_pulse[8:4], ack_pulse[10], ack_pulse[9], ack_pulse[3:2], {3{ack_pulse[0]}}};
    assign raw_next = (raw_reg & ~clr) | set_raw;
    // Requests stay up until taken, like a peripheral's pending flag.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            raw_reg <= 12'h000;
        end else begin
            raw_reg <= raw_next;
        end
    end
    assign timer_req   = raw_reg[2:0];
    assign dma_req     = raw_reg[4:3];
    assign wdog_req    = raw_reg[5];
    assign serial_req  = raw_reg[6];
    assign ext_req_pin = raw_reg[11:7];
endmodule

/* sim/tb.sv */
// Purpose: Self-checking bench for the mask, poll and end-of-service block.
// Assumes: Master types are 16 plus the source index; slave types come from the vector base.
// Notes:   Expected words are computed from the source model state and bench mirrors.
`timescale 1ns/100ps
module tb;
    import imp_pkg::*;
    function automatic logic [54:0] mk_map();
        logic [54:0] m;
        for (int i = 0; i < 11; i++) m[5*i+:5] = 5'(16 + i);
        return m;
    endfunction
    localparam logic [54:0] TMAP = mk_map();  // Distinct type per source.
    logic        clk = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, slave = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, r;
    logic [32:0] src_prio = 33'h0;
    logic [11:0] set_raw = 12'h000;
    logic [2:0]  timer_req, thr;
    logic [1:0]  dma_req;
    logic        wdog_req, serial_req, cpu_int_req, evt_irq;
    logic [4:0]  ext_req_pin, vb;
    logic [10:0] ctrl_mask, ack_pulse, msk, ins;
    logic [7:0]  cpu_vec_type;
    logic [9:0]  vec_offset;
    int          errors = 0, check_count = 0, bi;
    always #5 clk = ~clk;
    imp_ctrl #(.TYPE_MAP(TMAP)) uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .timer_req(timer_req), .dma_req(dma_req), .wdog_req(wdog_req),
        .serial_req(serial_req), .ext_req_pin(ext_req_pin), .src_prio(src_prio), .ctrl_mask(ctrl_mask),
        .ack_pulse(ack_pulse), .cpu_int_req(cpu_int_req), .cpu_vec_type(cpu_vec_type),
        .vec_offset(vec_offset), .evt_irq(evt_irq));
    imp_src_model src (.clk(clk), .nrst(nrst), .set_raw(set_raw), .slave(slave), .ack_pulse(ack_pulse),
        .timer_req(timer_req), .dma_req(dma_req), .wdog_req(wdog_req), .serial_req(serial_req),
        .ext_req_pin(ext_req_pin));
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Returns just after the write edge, once the write has landed.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a; rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    // Four cycles cover the pin synchroniser and the registered request.
    task automatic raise(input logic [11:0] v);
        @(posedge clk);
        set_raw <= v;
        @(posedge clk);
        set_raw <= 12'h000;
        repeat (4) @(posedge clk);
    endtask
    // Expected poll word: best eligible source, lowest priority value, ties to lowest index.
    function automatic logic [15:0] pk(input logic sl);
        logic [11:0] w; logic [10:0] el; logic [2:0] p;
        w  = src.raw_reg;
        bi = -1;
        el = (sl ? {5'h0, w[2], w[1], w[4:3], 1'b0, w[0]} : {w[6], w[5], w[11:7], w[4:3], 1'b0, |w[2:0]})
             & ~msk & (sl ? VALID_S : VALID_M) & ~ins;
        for (int i = 0; i < NSRC; i++) begin
            p = src_prio[3*i+:3];
            if (el[i] && p <= thr && (bi < 0 || p < src_prio[3*bi+:3])) bi = i;
        end
        if (bi < 0) return 16'h0000;
        p = src_prio[3*bi+:3];
        return {1'b1, 10'h000, sl ? {vb[1:0], p} : 5'(16 + bi)};
    endfunction
    // Peek, then poll, re-raise the taken source while in service, end its service, peek again.
    task automatic step(input logic sl, input logic ns);
        logic [15:0] e; logic [11:0] w0; logic [2:0] p; logic [7:0] t8; int k;
        rd(A_PEEK, r); e = pk(sl); chk("peek", r, e);
        chk("int_req", {15'h0, cpu_int_req}, {15'h0, e[15]});
        chk("ctrl_mask", {5'h0, ctrl_mask}, {5'h0, msk & (sl ? VALID_S : VALID_M)});
        if (e[15]) begin
            k = bi; p = src_prio[3*k+:3];
            t8 = sl ? {vb, p} : 8'(16 + k);
            chk("vec_type", {8'h0, cpu_vec_type}, {8'h0, t8});
            chk("vec_off", {6'h0, vec_offset}, {6'h0, t8, 2'b00});
            w0 = src.raw_reg;
            rd(A_POLL, r); chk("poll", r, e);
            chk("ack", {5'h0, ack_pulse}, {5'h0, 11'h1 << k});
            ins[k] = 1'b1;
            @(posedge clk);
            #1 raise(w0 & ~src.raw_reg);
            rd(A_PEEK, r); chk("blocked", r, pk(sl));
            wr(A_EOI, sl ? {13'h0, p} : ns ? 16'h8000 : {11'h0, 5'(16 + k)});
            ins[k] = 1'b0;
            rd(A_PEEK, r); chk("after_eoi", r, pk(sl));
        end
    endtask
    initial begin
        #900000;
        errors++;
        report_and_stop();
    end
    initial begin
        r = 16'($urandom(32'hB16A));
        thr = 3'h7; msk = MASK_RST; ins = 11'h0; vb = 5'h00;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rd(A_THR, r); chk("thr_rst", r, 16'h0007);
        rd(A_MASK, r); chk("mask_rst", r, 16'h07FD);
        rd(A_PEEK, r); chk("peek_idle", r, 16'h0000);
        rd(8'h30, r); chk("unmapped", r, 16'h0000);
        rd(A_EOI, r); chk("eoi_wo", r, 16'h0000);
        wr(A_THR, 16'hFFFC); thr = 3'h4;
        rd(A_THR, r); chk("thr_rsv", r, 16'h0004);
        wr(A_MASK, 16'hFFFF); msk = 11'h7FF;
        rd(A_MASK, r); chk("mask_rsv", r, 16'h07FD);
        for (int i = 0; i < 24; i++) begin
            thr = 3'($urandom); msk = 11'($urandom); src_prio <= 33'({$urandom, $urandom});
            wr(A_THR, {13'h0, thr}); wr(A_MASK, {5'h0, msk});
            raise(12'($urandom));
            step(1'b0, i[0]);
        end
        // Only the timer source open; one timer alone must raise it.
        msk = 11'h7FE; thr = 3'h7; wr(A_MASK, 16'h07FE); wr(A_THR, 16'h0007);
        wr(A_EVCLR, 16'h0007); wr(A_EVEN, 16'h0002);
        raise(12'h004);
        step(1'b0, 1'b0);
        rd(A_EVST, r); chk("ev_ack", r & 16'h0002, 16'h0002);
        chk("irq_on", {15'h0, evt_irq}, 16'h0001);
        wr(A_EVEN, 16'h0000); chk("irq_mask", {15'h0, evt_irq}, 16'h0000);
        wr(A_EVEN, 16'h0002); wr(A_EVCLR, 16'h0002);
        chk("irq_clr", {15'h0, evt_irq}, 16'h0000);
        rd(A_EVST, r); chk("ev_clr", r & 16'h0002, 16'h0000);
        wr(A_EOI, 16'h8000);
        rd(A_EVST, r); chk("ev_orph", r & 16'h0004, 16'h0004);
        // Special nesting: a taken external input may be reported again.
        msk = 11'h7EF; wr(A_CFG, 16'h0002); wr(A_MASK, 16'h07EF);
        raise(12'h080); rd(A_POLL, r); chk("sfnm_poll", r, 16'h8014);
        raise(12'h080); rd(A_PEEK, r); chk("sfnm_nest", r, 16'h8014);
        wr(A_EOI, 16'h0014); wr(A_CFG, 16'h0000);
        rd(A_PEEK, r); chk("sfnm_eoi", r, 16'h8014);
        // Slave view of the same store, then the vector base and slave service.
        wr(A_CFG, 16'h0001); slave <= 1'b1;
        rd(A_MASK, r); chk("mask_slv", r, {5'h0, msk & VALID_S});
        wr(A_VEC, 16'hFFFF); rd(A_VEC, r); chk("vec_rsv", r, 16'h00F8);
        for (int i = 0; i < 10; i++) begin
            vb = 5'($urandom); thr = 3'($urandom); msk = 11'($urandom) & 11'h7C2;
            src_prio <= 33'({$urandom, $urandom});
            wr(A_VEC, {8'h0, vb, 3'h0}); wr(A_THR, {13'h0, thr}); wr(A_MASK, {5'h0, msk});
            raise(12'($urandom));
            step(1'b1, 1'b0);
        end
        report_and_stop();
    end
endmodule
